// ===== design/irq_pkg.sv
package irq_pkg;

    // Sizing defaults.
    localparam int NUM_TIMERS  = 4;
    localparam int NUM_GROUPS  = 2;
    localparam int PC_WIDTH    = 14;
    localparam int STACK_DEPTH = 12;
    localparam int ADDR_WIDTH  = 4;
    localparam int DATA_WIDTH  = 8;

    // Register map (word offsets on the plain port).
    localparam logic [3:0] OFS_CTRL      = 4'h0;
    localparam logic [3:0] OFS_SRC_FLAG  = 4'h1;
    localparam logic [3:0] OFS_SRC_EN_P  = 4'h2;
    localparam logic [3:0] OFS_SRC_EN_A  = 4'h3;
    localparam logic [3:0] OFS_GRP_EN    = 4'h4;
    localparam logic [3:0] OFS_GRP_FLAG  = 4'h5;
    localparam logic [3:0] OFS_EVT_STAT  = 4'h6;
    localparam logic [3:0] OFS_EVT_MASK  = 4'h7;
    localparam logic [3:0] OFS_STACK_LVL = 4'h8;

    // Bit positions in the control register.
    localparam int CTRL_GIE_BIT   = 0;
    localparam int CTRL_SLEEP_BIT = 1;

    // Event status bit positions.
    localparam int EVT_WAKE_BIT  = 0;
    localparam int EVT_ENTRY_BIT = 1;
    localparam int EVT_OVF_BIT   = 2;
    localparam int EVT_WIDTH     = 3;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // One comparator pair per timer unit: P and A match strobes.
    typedef struct packed {
        logic match_p;
        logic match_a;
    } timer_match_t;

    // Core sequencer handshake.
    typedef struct packed {
        logic take_entry;
        logic irq_ret;
        logic plain_ret;
    } core_cmd_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTRY,
        ST_RETURN
    } seq_state_t;

endpackage

// ===== design/wake_edge.sv
`timescale 1ns/10ps
// Rising-edge detector on a request flag, with a two-stage input
// synchroniser for flags that may change with the system clock stopped.
module wake_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] flag_in,
    output logic                  rise
);
    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [WIDTH-1:0] last_reg;

    // The chain is not reset, so it already holds the flag level when
    // reset ends.
    always_ff @(posedge mclk) begin
        sync1_reg <= flag_in;
        sync2_reg <= sync1_reg;
    end

    // The history resets high: a flag that is already high at release,
    // such as one preset to block wake-up, must not look like a new edge.
    always_ff @(posedge mclk) begin
        if (reset) begin
            last_reg <= '1;
        end else begin
            last_reg <= sync2_reg;
        end
    end

    assign rise = |(sync2_reg & ~last_reg);
endmodule

// ===== design/grouped_timer_interrupt_wakeup.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module grouped_timer_interrupt_wakeup
    import irq_pkg::*;
#(
    parameter int NT = NUM_TIMERS,
    parameter int NG = NUM_GROUPS,
    parameter int PW = PC_WIDTH,
    parameter int SD = STACK_DEPTH
) (
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire logic [ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [DATA_WIDTH-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [DATA_WIDTH-1:0] reg_rdata,
    input  wire timer_match_t [NT-1:0] compare_timer_unit,
    input  wire logic [NT-1:0]         timer_group_map,
    input  wire logic                  ext_pin_flag,
    input  wire logic                  low_supply_flag,
    input  wire core_cmd_t             core_cmd,
    input  wire logic [PW-1:0]         core_pc,
    output logic                       irq_request,
    output logic [$clog2(NG)-1:0]      vector_group,
    output logic [PW-1:0]              return_pc,
    output logic                       stack_full,
    output logic                       wake_up,
    output logic                       irq_out
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [NT-1:0]          flag_p_reg;
    logic [NT-1:0]          flag_a_reg;
    logic [NT-1:0]          en_p_reg;
    logic [NT-1:0]          en_a_reg;
    logic [NG-1:0]          group_irq_enable;
    logic [NG-1:0]          group_irq_flag;
    logic                   global_irq_enable;
    logic                   sleep_reg;
    logic [EVT_WIDTH-1:0]   evt_stat_reg;
    logic [EVT_WIDTH-1:0]   evt_mask_reg;
    logic [PW-1:0]          stack_mem [SD];
    logic [$clog2(SD+1)-1:0] sp_reg;
    logic [DATA_WIDTH-1:0]  rdata_next;
    seq_state_t             state_reg;

    logic                   wr_ctrl;
    logic                   wr_flag;
    logic [NT-1:0]          set_p;
    logic [NT-1:0]          set_a;
    logic [NG-1:0]          grp_set;
    logic [NG-1:0]          grp_ready;
    logic [NG-1:0]          grp_pick;
    logic [$clog2(NG)-1:0]  pick_idx;
    logic                   entry_ok;
    logic                   do_entry;
    logic                   do_pop;
    logic                   wake_timer;
    logic                   wake_ext;
    logic                   overflow_evt;
    logic [EVT_WIDTH-1:0]   evt_now;

    assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    assign wr_flag = reg_wr && (reg_addr == OFS_SRC_FLAG);

    // ****************************************************************
    // Source request flags
    // ****************************************************************
    always_comb begin
        set_p = '0;
        set_a = '0;
        for (int i = 0; i < NT; i++) begin
            set_p[i] = compare_timer_unit[i].match_p;
            set_a[i] = compare_timer_unit[i].match_a;
        end
    end

    // Flag register layout: P flags in the low half, A flags above.
    // Writing a one clears; a match in the same cycle wins over the clear.
    always_ff @(posedge mclk) begin
        if (reset) begin
            flag_p_reg <= '0;
            flag_a_reg <= '0;
        end else begin
            flag_p_reg <= set_p | (flag_p_reg
                & ~(wr_flag ? reg_wdata[NT-1:0] : '0));
            flag_a_reg <= set_a | (flag_a_reg
                & ~(wr_flag ? reg_wdata[2*NT-1:NT] : '0));
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            en_p_reg <= '0;
            en_a_reg <= '0;
        end else begin
            if (reg_wr && reg_addr == OFS_SRC_EN_P) begin
                en_p_reg <= reg_wdata[NT-1:0];
            end
            if (reg_wr && reg_addr == OFS_SRC_EN_A) begin
                en_a_reg <= reg_wdata[NT-1:0];
            end
        end
    end

    // ****************************************************************
    // Group flags and selection
    // ****************************************************************
    // A source contributes to its group only when its own enable is set,
    // so a disabled source leaves the group idle but keeps its flag.
    always_comb begin
        grp_set = '0;
        for (int i = 0; i < NT; i++) begin
            if ((set_p[i] && en_p_reg[i]) || (set_a[i] && en_a_reg[i])) begin
                grp_set[timer_group_map[i]] = 1'b1;
            end
        end
    end

    always_comb begin
        grp_ready = group_irq_flag & group_irq_enable;
        grp_pick  = grp_ready & (~grp_ready + 1'b1);
        pick_idx  = '0;
        for (int g = NG - 1; g >= 0; g--) begin
            if (grp_ready[g]) begin
                pick_idx = g[$clog2(NG)-1:0];
            end
        end
    end

    assign stack_full = (sp_reg == SD[$clog2(SD+1)-1:0]);
    assign entry_ok   = global_irq_enable && (|grp_ready)
                        && !stack_full;
    assign irq_request  = entry_ok && (state_reg == ST_RUN);
    assign vector_group = pick_idx;
    assign do_entry     = irq_request && core_cmd.take_entry;
    assign do_pop       = (core_cmd.irq_ret || core_cmd.plain_ret)
                          && (sp_reg != '0);

    // Set wins over the automatic clear and the software clear.
    always_ff @(posedge mclk) begin
        if (reset) begin
            group_irq_flag <= '0;
        end else begin
            group_irq_flag <= grp_set | (group_irq_flag
                & ~(do_entry ? grp_pick : '0)
                & ~((reg_wr && reg_addr == OFS_GRP_FLAG)
                    ? reg_wdata[NG-1:0] : '0));
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            group_irq_enable <= '0;
        end else if (reg_wr && reg_addr == OFS_GRP_EN) begin
            group_irq_enable <= reg_wdata[NG-1:0];
        end
    end

    // ****************************************************************
    // Global enable and sequencing
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            global_irq_enable <= 1'b0;
        end else if (do_entry) begin
            global_irq_enable <= 1'b0;
        end else if (core_cmd.irq_ret) begin
            global_irq_enable <= 1'b1;
        end else if (wr_ctrl) begin
            global_irq_enable <= reg_wdata[CTRL_GIE_BIT];
        end
    end
    // A plain return falls through above and leaves the enable as is.

    always_ff @(posedge mclk) begin
        if (reset) begin
            sleep_reg <= 1'b0;
        end else if (wake_up) begin
            sleep_reg <= 1'b0;
        end else if (wr_ctrl) begin
            sleep_reg <= reg_wdata[CTRL_SLEEP_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (do_entry) begin
                        state_reg <= ST_ENTRY;
                    end else if (do_pop) begin
                        state_reg <= ST_RETURN;
                    end
                end
                ST_ENTRY:  state_reg <= ST_RUN;
                ST_RETURN: state_reg <= ST_RUN;
                default:   state_reg <= ST_RUN;
            endcase
        end
    end

    // ****************************************************************
    // Return-address stack
    // ****************************************************************
    // Only the program counter is kept; the service routine must save
    // the accumulator and status itself.
    always_ff @(posedge mclk) begin
        if (reset) begin
            sp_reg <= '0;
        end else if (do_entry) begin
            sp_reg <= sp_reg + 1'b1;
        end else if (do_pop && state_reg == ST_RUN) begin
            sp_reg <= sp_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (do_entry) begin
            stack_mem[sp_reg[$clog2(SD)-1:0]] <= core_pc;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            return_pc <= '0;
        end else if (do_pop && state_reg == ST_RUN) begin
            return_pc <= stack_mem[sp_reg[$clog2(SD)-1:0] - 1'b1];
        end
    end

    // ****************************************************************
    // Wake-up
    // ****************************************************************
    // Watching every flag, enabled or not, means a preset-high flag
    // cannot produce a rising edge and so cannot wake the part.
    assign wake_timer = (|(set_p & ~flag_p_reg))
                        || (|(set_a & ~flag_a_reg));

    wake_edge #(
        .WIDTH(2)
    ) u_wake_ext (
        .mclk    (mclk),
        .reset   (reset),
        .flag_in ({ext_pin_flag, low_supply_flag}),
        .rise    (wake_ext)
    );

    assign wake_up = wake_timer || wake_ext;

    // ****************************************************************
    // Event status, mask and interrupt line
    // ****************************************************************
    assign overflow_evt = core_cmd.take_entry && stack_full;
    always_comb begin
        evt_now = '0;
        evt_now[EVT_WAKE_BIT]  = wake_up;
        evt_now[EVT_ENTRY_BIT] = do_entry;
        evt_now[EVT_OVF_BIT]   = overflow_evt;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            evt_stat_reg <= '0;
        end else begin
            evt_stat_reg <= evt_now | (evt_stat_reg
                & ~((reg_wr && reg_addr == OFS_EVT_STAT)
                    ? reg_wdata[EVT_WIDTH-1:0] : '0));
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            evt_mask_reg <= '0;
        end else if (reg_wr && reg_addr == OFS_EVT_MASK) begin
            evt_mask_reg <= reg_wdata[EVT_WIDTH-1:0];
        end
    end

    assign irq_out = |(evt_stat_reg & evt_mask_reg);

    // ****************************************************************
    // Register read port
    // ****************************************************************
    always_comb begin
        rdata_next = RESET_BYTE;
        case (reg_addr)
            OFS_CTRL: begin
                rdata_next[CTRL_GIE_BIT]   = global_irq_enable;
                rdata_next[CTRL_SLEEP_BIT] = sleep_reg;
            end
            OFS_SRC_FLAG:  rdata_next[2*NT-1:0] = {flag_a_reg, flag_p_reg};
            OFS_SRC_EN_P:  rdata_next[NT-1:0]   = en_p_reg;
            OFS_SRC_EN_A:  rdata_next[NT-1:0]   = en_a_reg;
            OFS_GRP_EN:    rdata_next[NG-1:0]   = group_irq_enable;
            OFS_GRP_FLAG:  rdata_next[NG-1:0]   = group_irq_flag;
            OFS_EVT_STAT:  rdata_next[EVT_WIDTH-1:0] = evt_stat_reg;
            OFS_EVT_MASK:  rdata_next[EVT_WIDTH-1:0] = evt_mask_reg;
            OFS_STACK_LVL: rdata_next[$clog2(SD+1)-1:0] = sp_reg;
            default:       rdata_next = RESET_BYTE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= RESET_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= RESET_BYTE;
        end
    end
endmodule

// ===== dv/gtiw_asserts.sv
`timescale 1ns/10ps
// ******
// Handshake, stack and wake-up checks.
// ******
module gtiw_asserts
    import irq_pkg::*;
#(
    parameter int NT = NUM_TIMERS,
    parameter int NG = NUM_GROUPS,
    parameter int PW = PC_WIDTH,
    parameter int SD = STACK_DEPTH
) (
    input wire logic                  mclk,
    input wire logic                  reset,
    input wire logic                  reg_wr,
    input wire timer_match_t [NT-1:0] compare_timer_unit,
    input wire logic                  ext_pin_flag,
    input wire logic                  low_supply_flag,
    input wire core_cmd_t             core_cmd,
    input wire logic [PW-1:0]         core_pc,
    input wire logic                  irq_request,
    input wire logic [$clog2(NG)-1:0] vector_group,
    input wire logic [PW-1:0]         return_pc,
    input wire logic                  stack_full,
    input wire logic                  wake_up
);
    // A shadow stack checks popped addresses without the design's pointer.
    logic [PW-1:0] stk_reg [SD];
    int            sp_reg;
    logic [PW-1:0] top_pc;
    logic          push;
    logic          pop;
    logic          quiet;
    assign push   = core_cmd.take_entry && irq_request;
    assign pop    = (core_cmd.irq_ret || core_cmd.plain_ret) && sp_reg > 0;
    assign top_pc = (sp_reg > 0) ? stk_reg[sp_reg-1] : '0;
    assign quiet  = (compare_timer_unit == '0) && !reg_wr;
    always_ff @(posedge mclk) begin
        if (reset) begin
            sp_reg <= 0;
        end else if (push) begin
            stk_reg[sp_reg] <= core_pc;
            sp_reg          <= sp_reg + 1;
        end else if (pop) begin
            sp_reg <= sp_reg - 1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_full_no_req: assert property (stack_full |-> !irq_request)
        else $error("request with full stack");
    a_full_depth: assert property (stack_full == (sp_reg == SD))
        else $error("full flag wrong");
    a_entry_drop: assert property (push |=> !irq_request [*2])
        else $error("request held after entry");
    a_pop_addr: assert property (
        pop |=> return_pc == $past(top_pc))
        else $error("wrong return address");
    a_pin_wake: assert property (
        $rose(ext_pin_flag) |-> ##[1:5] wake_up)
        else $error("no wake from pin");
    a_sup_wake: assert property (
        $rose(low_supply_flag) |-> ##[1:5] wake_up)
        else $error("no wake from supply");
    a_plain_hold: assert property (
        core_cmd.plain_ret && !irq_request && !stack_full && quiet
        |=> !irq_request)
        else $error("request after plain return");
    a_vec_hold: assert property (
        irq_request && !core_cmd.take_entry && quiet
        |=> $stable(vector_group))
        else $error("vector moved while pending");
    c_push: cover property (push);
    c_pop: cover property (pop);
    c_full: cover property (stack_full);
endmodule

bind grouped_timer_interrupt_wakeup gtiw_asserts #(
    .NT(NT),
    .NG(NG),
    .PW(PW),
    .SD(SD)
) chk_i (
    .mclk, .reset, .reg_wr, .compare_timer_unit, .ext_pin_flag,
    .low_supply_flag, .core_cmd, .core_pc, .irq_request, .vector_group,
    .return_pc, .stack_full, .wake_up
);

// ===== dv/core_seq_model.sv
`timescale 1ns/10ps
// ******
// Core stand-in: takes entries and issues returns.
// ******
module core_seq_model
    import irq_pkg::*;
#(
    parameter int PW = PC_WIDTH
) (
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic          take_en,
    input  wire logic [1:0]    ret_sel,
    input  wire logic          irq_request,
    output core_cmd_t          core_cmd,
    output logic      [PW-1:0] core_pc
);
    // The counter runs every cycle so each entry pushes a new address.
    always_ff @(posedge mclk) begin
        if (reset) begin
            core_cmd <= '0;
            core_pc  <= '0;
        end else begin
            // A gap after each entry, since the request needs a cycle to drop.
            core_cmd.take_entry <= take_en && irq_request
                                   && !core_cmd.take_entry;
            core_cmd.irq_ret    <= ret_sel[1];
            core_cmd.plain_ret  <= ret_sel[0];
            core_pc             <= core_pc + 1'h1;
        end
    end
endmodule

// ===== dv/grouped_timer_interrupt_wakeup_tb.sv
`timescale 1ns/10ps
module grouped_timer_interrupt_wakeup_tb;
    import irq_pkg::*;
    localparam int SDV = 4;
    typedef struct packed {
        logic [2:0] sel;
        logic       en;
        logic       grp;
        logic [7:0] src;
        logic [7:0] gfl;
    } row_t;
    logic                          mclk;
    logic                          reset;
    logic                          reg_wr;
    logic                          reg_rd;
    logic [ADDR_WIDTH-1:0]         reg_addr;
    logic [DATA_WIDTH-1:0]         reg_wdata;
    logic [DATA_WIDTH-1:0]         reg_rdata;
    timer_match_t [NUM_TIMERS-1:0] compare_timer_unit;
    logic [NUM_TIMERS-1:0]         timer_group_map;
    logic                          ext_pin_flag;
    logic                          low_supply_flag;
    logic                          take_en;
    logic [1:0]                    ret_sel;
    core_cmd_t                     core_cmd;
    logic [PC_WIDTH-1:0]           core_pc;
    logic [PC_WIDTH-1:0]           return_pc;
    logic [PC_WIDTH-1:0]           pcs [SDV];
    logic                          irq_request;
    logic [0:0]                    vector_group;
    logic                          stack_full;
    logic                          wake_up;
    logic                          irq_out;
    logic                          seen;
    logic                          v;
    row_t                          r;
    int                            t;
    int                            fails;
    int                            cmp_count;
    int                            cyc;
    row_t rows [8] = '{
        '{3'h0, 1'h1, 1'h0, 8'h01, 8'h01}, '{3'h1, 1'h1, 1'h1, 8'h02, 8'h02},
        '{3'h2, 1'h0, 1'h0, 8'h04, 8'h00}, '{3'h3, 1'h1, 1'h1, 8'h08, 8'h02},
        '{3'h4, 1'h1, 1'h0, 8'h10, 8'h01}, '{3'h5, 1'h0, 1'h1, 8'h20, 8'h00},
        '{3'h6, 1'h1, 1'h1, 8'h40, 8'h02}, '{3'h7, 1'h1, 1'h0, 8'h80, 8'h01}};
    grouped_timer_interrupt_wakeup #(.SD(SDV)) dut (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .compare_timer_unit(compare_timer_unit),
        .timer_group_map(timer_group_map), .ext_pin_flag(ext_pin_flag),
        .low_supply_flag(low_supply_flag), .core_cmd(core_cmd),
        .core_pc(core_pc), .irq_request(irq_request),
        .vector_group(vector_group), .return_pc(return_pc),
        .stack_full(stack_full), .wake_up(wake_up), .irq_out(irq_out)
    );
    core_seq_model core (
        .mclk(mclk), .reset(reset), .take_en(take_en), .ret_sel(ret_sel),
        .irq_request(irq_request), .core_cmd(core_cmd), .core_pc(core_pc)
    );
    // ******
    // Bus, event and check tasks.
    // ******
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        chk(16'(reg_rdata), 16'(e));
    endtask
    task automatic hit(input int n, input logic a);
        @(posedge mclk);
        compare_timer_unit[n] <= a ? 2'h1 : 2'h2;
        @(posedge mclk);
        compare_timer_unit <= '0;
    endtask
    task automatic watch(output logic w);
        w = 1'h0;
        repeat (6) begin
            @(negedge mclk);
            w |= wake_up;
        end
    endtask
    task automatic entry(output logic [PC_WIDTH-1:0] p, output logic g);
        @(posedge mclk iff (core_cmd.take_entry && irq_request));
        p = core_pc;
        g = vector_group;
    endtask
    task automatic pop_chk(input logic [1:0] k, input logic [13:0] e);
        @(posedge mclk);
        ret_sel <= k;
        @(posedge mclk);
        ret_sel <= 2'h0;
        @(posedge mclk);
        #1;
        chk(16'(return_pc), 16'(e));
    endtask
    task automatic pin(input logic [1:0] lv);
        fork
            begin
                @(posedge mclk);
                {low_supply_flag, ext_pin_flag} <= lv;
            end
            watch(seen);
        join
        chk(16'(seen), 16'h0001);
    endtask
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end
    // ******
    // Main sequence.
    // ******
    initial begin
        reset = 1'h1;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        compare_timer_unit = '0;
        timer_group_map = 4'h0;
        {low_supply_flag, ext_pin_flag} = 2'h0;
        take_en = 1'h0;
        ret_sel = 2'h0;
        repeat (20) @(posedge mclk);
        reset <= 1'h0;
        foreach (rows[i]) begin
            r = rows[i];
            t = int'(r.sel[1:0]);
            timer_group_map <= r.grp ? 4'(1 << t) : 4'h0;
            wr(OFS_SRC_EN_P, (r.en && !r.sel[2]) ? 8'(1 << t) : 8'h00);
            wr(OFS_SRC_EN_A, (r.en && r.sel[2]) ? 8'(1 << t) : 8'h00);
            hit(t, r.sel[2]);
            rd(OFS_SRC_FLAG, r.src);
            rd(OFS_GRP_FLAG, r.gfl);
            wr(OFS_SRC_FLAG, 8'hFF);
            wr(OFS_GRP_FLAG, 8'hFF);
        end
        rd(4'hF, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        wr(OFS_SRC_EN_P, 8'h03);
        timer_group_map <= 4'h2;
        wr(OFS_GRP_EN, 8'h03);
        wr(OFS_EVT_MASK, 8'h02);
        wr(OFS_CTRL, 8'h01);
        take_en <= 1'h1;
        @(posedge mclk);
        compare_timer_unit <= 8'h0A;
        @(posedge mclk);
        compare_timer_unit <= '0;
        entry(pcs[0], v);
        chk(16'(v), 16'h0000);
        rd(OFS_GRP_FLAG, 8'h02);
        rd(OFS_SRC_FLAG, 8'h03);
        rd(OFS_CTRL, 8'h00);
        chk(16'(irq_out), 16'h0001);
        wr(OFS_EVT_MASK, 8'h00);
        #1;
        chk(16'(irq_out), 16'h0000);
        wr(OFS_EVT_STAT, 8'hFF);
        wr(OFS_EVT_MASK, 8'h02);
        #1;
        chk(16'(irq_out), 16'h0000);
        pop_chk(2'h2, pcs[0]);
        entry(pcs[0], v);
        chk(16'(v), 16'h0001);
        pop_chk(2'h1, pcs[0]);
        rd(OFS_CTRL, 8'h00);
        take_en <= 1'h0;
        wr(OFS_SRC_FLAG, 8'hFF);
        wr(OFS_GRP_EN, 8'h00);
        wr(OFS_CTRL, 8'h01);
        hit(0, 1'h0);
        repeat (3) @(posedge mclk);
        chk(16'(irq_request), 16'h0000);
        wr(OFS_GRP_EN, 8'h01);
        repeat (5) @(posedge mclk);
        chk(16'(irq_request), 16'h0001);
        take_en <= 1'h1;
        entry(pcs[0], v);
        for (int k = 1; k < SDV; k++) begin
            wr(OFS_SRC_FLAG, 8'hFF);
            wr(OFS_CTRL, 8'h01);
            hit(0, 1'h0);
            entry(pcs[k], v);
        end
        rd(OFS_STACK_LVL, 8'(SDV));
        wr(OFS_SRC_FLAG, 8'hFF);
        wr(OFS_CTRL, 8'h01);
        hit(0, 1'h0);
        repeat (3) @(posedge mclk);
        chk(16'({stack_full, irq_request}), 16'h0002);
        wr(OFS_GRP_FLAG, 8'hFF);
        for (int k = SDV - 1; k >= 0; k--) begin
            pop_chk(2'h2, pcs[k]);
        end
        rd(OFS_STACK_LVL, 8'h00);
        wr(OFS_SRC_EN_P, 8'h00);
        wr(OFS_GRP_EN, 8'h00);
        wr(OFS_SRC_FLAG, 8'hFF);
        wr(OFS_CTRL, 8'h02);
        rd(OFS_CTRL, 8'h02);
        fork hit(2, 1'h1); watch(seen); join
        chk(16'(seen), 16'h0001);
        rd(OFS_CTRL, 8'h00);
        fork hit(2, 1'h1); watch(seen); join
        chk(16'(seen), 16'h0000);
        pin(2'h1);
        pin(2'h3);
        @(posedge mclk);
        reset <= 1'h1;
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        watch(seen);
        chk(16'(seen), 16'h0000);
        rd(OFS_SRC_FLAG, 8'h00);
        wrap_up();
    end
endmodule
